/* File: core/exec_pkg.sv */
package exec_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int PADDR_W = 8;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] OPERAND_OFF = 8'h04;
  localparam logic [7:0] STACK_OFF = 8'h08;
  localparam logic [7:0] PC_OFF = 8'h0c;
  localparam logic [7:0] STATUS_WORD_OFF = 8'h10;
  localparam logic [7:0] RESULT_OFF = 8'h14;
  localparam logic [7:0] STATE_OFF = 8'h18;

  // control and state register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BYTE_BIT = 4;
  localparam int CTRL_DST_REG_BIT = 5;
  localparam int STATE_BUSY_BIT = 0;
  localparam int STATE_DONE_BIT = 1;

  // status_word bit positions and the width kept by interrupt_return
  localparam int SW_CARRY = 0;
  localparam int SW_ZERO = 1;
  localparam int SW_NEG = 2;
  localparam int SW_GIE = 3;
  localparam int SW_CPU_OFF = 4;
  localparam int SW_OSC_OFF = 5;
  localparam int SW_OVF = 8;
  localparam int SW_KEEP_W = 12;

  // values after reset and the stack pointer step
  localparam logic [19:0] STACK_RST = 20'h00000;
  localparam logic [19:0] PC_RST = 20'h00000;
  localparam logic [15:0] STATUS_WORD_RST = 16'h0000;
  localparam logic [19:0] STACK_STEP = 20'h00002;

  // overflow windows of the left shifts
  localparam logic [15:0] WORD_OVF_LO = 16'h4000;
  localparam logic [15:0] WORD_OVF_HI = 16'hc000;
  localparam logic [7:0] BYTE_OVF_LO = 8'h40;
  localparam logic [7:0] BYTE_OVF_HI = 8'hc0;

  typedef enum logic [2:0] {
    no_operation = 3'h0,
    pop_op = 3'h1,
    push_op = 3'h2,
    subroutine_return = 3'h3,
    interrupt_return = 3'h4,
    arith_left_shift = 3'h5,
    rotate_left_carry = 3'h6,
    arith_right_shift = 3'h7
  } op_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_mem1 = 2'b01,
    st_mem2 = 2'b11
  } state_type;

endpackage

/* File: core/shift_if.sv */
`timescale 1ns/1ps
interface shift_if;
  exec_pkg::op_type op;
  logic byte_mode;
  logic [15:0] operand;
  logic carry_in;
  logic [15:0] result;
  logic c_out;
  logic z_out;
  logic n_out;
  logic v_out;
  modport exec (output op, output byte_mode, output operand, output carry_in,
                input result, input c_out, input z_out, input n_out, input v_out);
  modport unit (input op, input byte_mode, input operand, input carry_in,
                output result, output c_out, output z_out, output n_out, output v_out);
endinterface

/* File: core/shift_unit.sv */
`timescale 1ns/1ps
module shift_unit (
  shift_if.unit sh
);

  logic msb;
  logic in_range;
  logic [15:0] res;

  always_comb begin
    msb = sh.byte_mode ? sh.operand[7] : sh.operand[15];
    in_range = sh.byte_mode ?
      (sh.operand[7:0] >= exec_pkg::BYTE_OVF_LO && sh.operand[7:0] < exec_pkg::BYTE_OVF_HI) :
      (sh.operand >= exec_pkg::WORD_OVF_LO && sh.operand < exec_pkg::WORD_OVF_HI);
    res = sh.operand;
    sh.c_out = 1'b0;
    sh.v_out = 1'b0;
    case (sh.op)
      exec_pkg::arith_left_shift: begin
        res = {sh.operand[14:0], 1'b0};
        sh.c_out = msb;
        sh.v_out = in_range;
      end
      exec_pkg::rotate_left_carry: begin
        res = {sh.operand[14:0], sh.carry_in};
        sh.c_out = msb;
        sh.v_out = in_range;
      end
      exec_pkg::arith_right_shift: begin
        // byte form only touches the low byte; the high byte is dealt with by the caller
        if (sh.byte_mode) begin
          res = {sh.operand[15:8], sh.operand[7], sh.operand[7:1]};
        end else begin
          res = {sh.operand[15], sh.operand[15:1]};
        end
        sh.c_out = sh.operand[0];
        sh.v_out = 1'b0;
      end
      default: begin
        res = sh.operand;
      end
    endcase
    sh.result = res;
    sh.n_out = sh.byte_mode ? res[7] : res[15];
    sh.z_out = sh.byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
  end

endmodule

/* File: core/stack_return_shift_exec.sv */
`timescale 1ns/1ps
module stack_return_shift_exec (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_be,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic dst_wr,
  output logic [15:0] dst_data
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  exec_pkg::state_type state_q, state_d;
  exec_pkg::op_type op_q, op_d;
  logic byte_q, byte_d;
  logic dst_reg_q, dst_reg_d;
  logic [15:0] operand_q, operand_d;
  logic [19:0] stack_q, stack_d;
  logic [19:0] pc_q, pc_d;
  logic [15:0] sw_q, sw_d;
  logic [15:0] result_q, result_d;
  logic done_q, done_d;
  logic dst_wr_q, dst_wr_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;

  logic setup_ph;
  logic acc_wr;
  logic start;
  logic finish;
  logic idle;
  logic mapped;
  exec_pkg::op_type new_op;
  logic [15:0] pop_val;

  shift_if sh ();

  shift_unit u_shift (
    .sh(sh.unit)
  );

  assign sh.op = new_op;
  assign sh.byte_mode = pwdata[exec_pkg::CTRL_BYTE_BIT];
  assign sh.operand = operand_q;
  assign sh.carry_in = sw_q[exec_pkg::SW_CARRY];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup_ph = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign idle = (state_q == exec_pkg::st_idle);
  assign start = acc_wr & (paddr == exec_pkg::CTRL_OFF) & idle;
  assign new_op = exec_pkg::op_type'(pwdata[exec_pkg::CTRL_OP_LSB +: 3]);

  always_comb begin
    mapped = 1'b1;
    prdata_d = 32'h0000_0000;
    case (paddr)
      exec_pkg::CTRL_OFF: begin
        prdata_d[exec_pkg::CTRL_OP_LSB +: 3] = op_q;
        prdata_d[exec_pkg::CTRL_BYTE_BIT] = byte_q;
        prdata_d[exec_pkg::CTRL_DST_REG_BIT] = dst_reg_q;
      end
      exec_pkg::OPERAND_OFF: begin
        prdata_d[15:0] = operand_q;
      end
      exec_pkg::STACK_OFF: begin
        prdata_d[19:0] = stack_q;
      end
      exec_pkg::PC_OFF: begin
        prdata_d[19:0] = pc_q;
      end
      exec_pkg::STATUS_WORD_OFF: begin
        prdata_d[15:0] = sw_q;
      end
      exec_pkg::RESULT_OFF: begin
        prdata_d[15:0] = result_q;
      end
      exec_pkg::STATE_OFF: begin
        prdata_d[exec_pkg::STATE_BUSY_BIT] = ~idle;
        prdata_d[exec_pkg::STATE_DONE_BIT] = done_q;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (setup_ph) begin
      pslverr_d = ~mapped;
    end else begin
      pslverr_d = pslverr_q;
      prdata_d = prdata_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // answer is prepared in the setup cycle, so the access phase never waits
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // byte destination merge: register destinations get a zero high byte
  function automatic logic [15:0] merge_byte(input logic [15:0] val, input logic [15:0] old,
                                             input logic to_reg);
    merge_byte = to_reg ? {8'h00, val[7:0]} : {old[15:8], val[7:0]};
  endfunction

  assign pop_val = byte_q ? merge_byte(mem_rdata, operand_q, dst_reg_q) : mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // execution sequencer
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    byte_d = byte_q;
    dst_reg_d = dst_reg_q;
    operand_d = operand_q;
    stack_d = stack_q;
    pc_d = pc_q;
    sw_d = sw_q;
    result_d = result_q;
    done_d = done_q;
    finish = 1'b0;

    // software writes, ignored while a sequence is running
    if (acc_wr && idle) begin
      case (paddr)
        exec_pkg::OPERAND_OFF: operand_d = pwdata[15:0];
        exec_pkg::STACK_OFF: stack_d = pwdata[19:0];
        exec_pkg::PC_OFF: pc_d = pwdata[19:0];
        exec_pkg::STATUS_WORD_OFF: sw_d = pwdata[15:0];
        default: begin
        end
      endcase
    end
    if (acc_wr && paddr == exec_pkg::STATE_OFF && pwdata[exec_pkg::STATE_DONE_BIT]) begin
      done_d = 1'b0;
    end
    if (start) begin
      op_d = new_op;
      byte_d = pwdata[exec_pkg::CTRL_BYTE_BIT];
      dst_reg_d = pwdata[exec_pkg::CTRL_DST_REG_BIT];
      done_d = 1'b0;
    end

    case (state_q)
      exec_pkg::st_idle: begin
        if (start) begin
          case (new_op)
            exec_pkg::no_operation: begin
              finish = 1'b1;
            end
            exec_pkg::push_op: begin
              stack_d = stack_q - exec_pkg::STACK_STEP;
              state_d = exec_pkg::st_mem1;
            end
            exec_pkg::pop_op, exec_pkg::subroutine_return, exec_pkg::interrupt_return: begin
              state_d = exec_pkg::st_mem1;
            end
            default: begin
              // shifts finish at once; mode bits are never written here
              result_d = byte_d ? merge_byte(sh.result, operand_q, dst_reg_d) : sh.result;
              sw_d[exec_pkg::SW_CARRY] = sh.c_out;
              sw_d[exec_pkg::SW_ZERO] = sh.z_out;
              sw_d[exec_pkg::SW_NEG] = sh.n_out;
              sw_d[exec_pkg::SW_OVF] = sh.v_out;
              finish = 1'b1;
            end
          endcase
        end
      end
      exec_pkg::st_mem1: begin
        if (mem_ack) begin
          case (op_q)
            exec_pkg::push_op: begin
              finish = 1'b1;
              state_d = exec_pkg::st_idle;
            end
            exec_pkg::pop_op: begin
              result_d = pop_val;
              stack_d = stack_q + exec_pkg::STACK_STEP;
              finish = 1'b1;
              state_d = exec_pkg::st_idle;
            end
            exec_pkg::subroutine_return: begin
              pc_d = {4'h0, mem_rdata};
              stack_d = stack_q + exec_pkg::STACK_STEP;
              finish = 1'b1;
              state_d = exec_pkg::st_idle;
            end
            default: begin
              // saved pc high bits share the word with the status bits
              sw_d = {4'h0, mem_rdata[exec_pkg::SW_KEEP_W-1:0]};
              pc_d[19:16] = mem_rdata[15:12];
              stack_d = stack_q + exec_pkg::STACK_STEP;
              state_d = exec_pkg::st_mem2;
            end
          endcase
        end
      end
      exec_pkg::st_mem2: begin
        if (mem_ack) begin
          pc_d[15:0] = mem_rdata;
          stack_d = stack_q + exec_pkg::STACK_STEP;
          finish = 1'b1;
          state_d = exec_pkg::st_idle;
        end
      end
      default: begin
        state_d = exec_pkg::st_idle;
      end
    endcase

    // completion beats a same-cycle clear of the done flag
    if (finish) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= exec_pkg::st_idle;
      op_q <= exec_pkg::no_operation;
      byte_q <= 1'b0;
      dst_reg_q <= 1'b0;
      operand_q <= 16'h0000;
      stack_q <= exec_pkg::STACK_RST;
      pc_q <= exec_pkg::PC_RST;
      sw_q <= exec_pkg::STATUS_WORD_RST;
      result_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      byte_q <= byte_d;
      dst_reg_q <= dst_reg_d;
      operand_q <= operand_d;
      stack_q <= stack_d;
      pc_q <= pc_d;
      sw_q <= sw_d;
      result_q <= result_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // destination strobe: only ops that produce a destination value raise it
  always_comb begin
    dst_wr_d = 1'b0;
    if (finish) begin
      case (op_d)
        exec_pkg::pop_op, exec_pkg::arith_left_shift: begin
          dst_wr_d = 1'b1;
        end
        exec_pkg::rotate_left_carry, exec_pkg::arith_right_shift: begin
          dst_wr_d = 1'b1;
        end
        default: begin
          dst_wr_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dst_wr_q <= 1'b0;
    end else begin
      dst_wr_q <= dst_wr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory side: request held until ack, address is always the live stack_pointer
  assign mem_req = (state_q != exec_pkg::st_idle);
  assign mem_we = (state_q == exec_pkg::st_mem1) && (op_q == exec_pkg::push_op);
  assign mem_be = byte_q ? 2'b01 : 2'b11;
  assign mem_addr = stack_q;
  assign mem_wdata = operand_q;
  assign dst_wr = dst_wr_q;
  assign dst_data = result_q;

endmodule

/* File: sim/exec_chk.sv */
`timescale 1ns/1ps
module exec_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_be,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic dst_wr,
  input wire logic [15:0] dst_data
);
  typedef struct packed {
    logic [2:0] op;
    logic bt;
    logic rg;
    logic [15:0] opnd;
    logic [15:0] ex;
    logic [19:0] sp;
  } shadow_type;
  shadow_type h_q, h_d;
  logic wr_acc, start;
  assign wr_acc = psel && penable && pwrite;
  assign start = wr_acc && paddr == exec_pkg::CTRL_OFF;
  // shadow stack follows apb writes and every completed memory access
  always_comb begin
    logic [7:0] lo;
    logic [15:0] wd;
    h_d = h_q;
    lo = pwdata[2:0] == 3'h5 ? {h_q.opnd[6:0], 1'b0} : {h_q.opnd[7], h_q.opnd[7:1]};
    wd = pwdata[2:0] == 3'h5 ? {h_q.opnd[14:0], 1'b0} : {h_q.opnd[15], h_q.opnd[15:1]};
    if (start) begin
      h_d.op = pwdata[2:0];
      h_d.bt = pwdata[4];
      h_d.rg = pwdata[5];
      h_d.ex = pwdata[4] ? {pwdata[5] ? 8'h00 : h_q.opnd[15:8], lo} : wd;
    end
    if (wr_acc && paddr == exec_pkg::OPERAND_OFF) h_d.opnd = pwdata[15:0];
    if (wr_acc && paddr == exec_pkg::STACK_OFF) h_d.sp = pwdata[19:0];
    if (mem_req && mem_ack) h_d.sp = mem_we ? h_q.sp - 20'h00002 : h_q.sp + 20'h00002;
    if (mem_req && mem_ack && !mem_we) begin
      h_d.ex = h_q.bt ? {h_q.rg ? 8'h00 : h_q.opnd[15:8], mem_rdata[7:0]} : mem_rdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) h_q <= '0;
    else h_q <= h_d;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_nop; start && pwdata[2:0] == 3'h0 |=> (!mem_req && !dst_wr)[*3]; endproperty
  a_nop: assert property (p_nop) else $error("nop touched memory or destination");
  property p_shift;
    start && (pwdata[2:0] == 3'h5 || pwdata[2:0] == 3'h7)
      |-> ##[1:2] (dst_wr && dst_data == h_q.ex);
  endproperty
  a_shift: assert property (p_shift) else $error("shift result wrong");
  property p_popd;
    mem_req && mem_ack && !mem_we && h_q.op == 3'h1 |-> ##[1:2] (dst_wr && dst_data == h_q.ex);
  endproperty
  a_popd: assert property (p_popd) else $error("pop result wrong");
  property p_pusha; $rose(mem_req) && mem_we |-> mem_addr == h_q.sp - 20'h00002; endproperty
  a_pusha: assert property (p_pusha) else $error("push address wrong");
  property p_popa; $rose(mem_req) && !mem_we |-> mem_addr == h_q.sp; endproperty
  a_popa: assert property (p_popa) else $error("read address wrong");
  property p_pushd;
    mem_req && mem_we |-> mem_wdata == h_q.opnd && mem_be == (h_q.bt ? 2'b01 : 2'b11);
  endproperty
  a_pushd: assert property (p_pushd) else $error("push data or lanes wrong");
  property p_step;
    mem_req && mem_ack && !mem_we && h_q.op == 3'h4 ##1 mem_req
      |-> mem_addr == $past(mem_addr) + 20'h00002;
  endproperty
  a_step: assert property (p_step) else $error("second read address wrong");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped early");
endmodule
bind stack_return_shift_exec exec_chk u_chk (.ref_clk(ref_clk), .reset(reset), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .mem_req(mem_req),
  .mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dst_wr(dst_wr), .dst_data(dst_data));

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mem_ack = 1'b0, err, go, b;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'haabe;
  logic pready, pslverr, mem_req, mem_we, dst_wr;
  logic [1:0] mem_be;
  logic [19:0] mem_addr, f;
  logic [15:0] mem_wdata, dst_data, mem_rdata = 16'h0, v, w1, w2, pre;
  logic [2:0] op;
  logic [15:0] exp_q[$], rdq[$];
  logic [17:0] mwq[$];
  logic [15:0] edge_v[8] = '{16'h4000, 16'h3fff, 16'hbfff, 16'hc000, 16'h0040, 16'h00bf,
    16'h0000, 16'h8000};
  int failures = 0, samples_checked = 0, cycles = 0, dly = 0, n;
  always #12.5 ref_clk = ~ref_clk;
  stack_return_shift_exec DUT (.ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_be(mem_be),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .dst_wr(dst_wr), .dst_data(dst_data));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [19:0] sh(input logic [2:0] o, input logic bm, input logic [15:0] x,
    input logic c);
    logic [15:0] r;
    r = o == 3'h7 ? {x[15], x[15:1]} : {x[14:0], o == 3'h6 ? c : 1'b0};
    if (bm) r = {8'h00, o == 3'h7 ? {x[7], x[7:1]} : r[7:0]};
    return {o != 3'h7 && (bm ? x[7:0] >= 8'h40 && x[7:0] < 8'hc0 : x >= 16'h4000 && x < 16'hc000),
      bm ? r[7] : r[15], r == 16'h0, o == 3'h7 ? x[0] : (bm ? x[7] : x[15]), r};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // destination always a register, so byte results carry a cleared high byte
  task run(input logic [2:0] o, input logic bm);
    apb(1'b1, exec_pkg::CTRL_OFF, {27'h1, bm, 1'b0, o});
    rd = 32'h0;
    for (n = 0; n < 40 && rd[1:0] !== 2'b10; n++) apb(1'b0, exec_pkg::STATE_OFF, 32'h0);
    chk("state", 32'h2, rd);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  // released data bus toggles so a stale word never looks valid
  always @(posedge ref_clk) begin
    if (dst_wr === 1'b1) begin
      if (exp_q.size() > 0) chk("dst_data", exp_q.pop_front(), dst_data);
      else chk("dst_wr", 32'h0, 32'h1);
    end
    go = mem_req === 1'b1 && !mem_ack && dly == 0;
    mem_ack <= go;
    mem_rdata <= (go && !mem_we) ? rdq.pop_front() : ~mem_rdata;
    if (go && mem_we) chk("mem_write", mwq.pop_front(), {mem_be, mem_wdata});
    if (go) dly = rnd() % 4;
    else if (mem_req === 1'b1 && !mem_ack) dly--;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rdc("stack", exec_pkg::STACK_OFF, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, exec_pkg::STATUS_WORD_OFF, 32'h013f);
    apb(1'b1, exec_pkg::OPERAND_OFF, 32'h1234);
    run(exec_pkg::no_operation, 1'b0);
    rdc("status", exec_pkg::STATUS_WORD_OFF, 32'h013f);
    apb(1'b1, exec_pkg::STACK_OFF, 32'h0);
    mwq.push_back({2'b11, 16'h1234});
    run(exec_pkg::push_op, 1'b0);
    rdc("stack", exec_pkg::STACK_OFF, 32'hffffe);
    apb(1'b1, exec_pkg::STACK_OFF, 32'h100);
    apb(1'b1, exec_pkg::OPERAND_OFF, 32'h5aa5);
    mwq.push_back({2'b01, 16'h5aa5});
    run(exec_pkg::push_op, 1'b1);
    rdc("status", exec_pkg::STATUS_WORD_OFF, 32'h013f);
    for (int i = 0; i < 2; i++) begin
      v = 16'(rnd());
      rdq.push_back(v);
      exp_q.push_back(i ? {8'h00, v[7:0]} : v);
      apb(1'b1, exec_pkg::STACK_OFF, 32'h200);
      run(exec_pkg::pop_op, i[0]);
      rdc("stack", exec_pkg::STACK_OFF, 32'h202);
    end
    apb(1'b1, exec_pkg::PC_OFF, 32'hf0000);
    v = 16'(rnd());
    rdq.push_back(v);
    run(exec_pkg::subroutine_return, 1'b0);
    rdc("pc", exec_pkg::PC_OFF, {16'h0, v});
    w1 = 16'(rnd());
    w2 = 16'(rnd());
    rdq.push_back(w1);
    rdq.push_back(w2);
    apb(1'b1, exec_pkg::STACK_OFF, 32'h400);
    run(exec_pkg::interrupt_return, 1'b0);
    rdc("status", exec_pkg::STATUS_WORD_OFF, {20'h0, w1[11:0]});
    rdc("pc", exec_pkg::PC_OFF, {12'h0, w1[15:12], w2});
    rdc("stack", exec_pkg::STACK_OFF, 32'h404);
    for (int k = 0; k < 24; k++) begin
      op = 3'(5 + k % 3);
      b = 1'((k / 3) % 2);
      v = k < 8 ? edge_v[k] : 16'(rnd());
      pre = 16'h0038 | 16'(k % 2);
      f = sh(op, b, v, pre[0]);
      apb(1'b1, exec_pkg::STATUS_WORD_OFF, {16'h0, pre});
      apb(1'b1, exec_pkg::OPERAND_OFF, {16'h0, v});
      exp_q.push_back(f[15:0]);
      run(op, b);
      rdc("flags", exec_pkg::STATUS_WORD_OFF,
        {16'h0, pre & 16'hfef8 | {7'h0, f[19], 5'h0, f[18:16]}});
    end
    chk("pending", 32'h0, 32'(exp_q.size()));
    final_report();
  end
endmodule
